// ===== pcs_cmd_bank.sv
// Bank of nine per-port command registers with their traffic gates.
// Assumes one config access per cycle from one of the three visible ports.
`timescale 1ns/1ps
`default_nettype none
module pcs_cmd_bank
    import pcs_pkg::*;
#(
    parameter int NP = PCS_NPORTS                      // Number of ports in the bank
)(
    input  wire logic          clk,         // Core clock, 10 MHz
    input  wire logic          rst_n,       // Sync reset, active low
    input  wire logic [3:0]    cfg_port,    // Port whose config space is accessed
    input  wire logic          cfg_wr,      // Config write strobe
    input  wire logic          cfg_rd,      // Config read strobe
    input  wire logic [11:0]   cfg_addr,    // Config byte offset
    input  wire logic [15:0]   cfg_wdata,   // Write data
    output logic [15:0]        cfg_rdata,   // Read data, registered
    output logic               cfg_hit,     // Read/write decoded, registered
    input  wire logic          ld_en,       // EEPROM/I2C preload strobe
    input  wire logic [11:0]   ld_addr,     // Preload offset
    input  wire logic [15:0]   ld_data,     // Preload data
    input  wire logic [NP-1:0] pri_req,     // Primary request strobes
    input  wire logic [2*NP-1:0] pri_type,  // Primary request types
    input  wire logic [NP-1:0] sec_req,     // Secondary request strobes
    input  wire logic [2*NP-1:0] sec_type,  // Secondary request types
    input  wire logic [NP-1:0] sec_np,      // Secondary non-posted flags
    input  wire logic [NP-1:0] err_det,     // Detected errors per port
    input  wire logic [NP-1:0] brg_fwd_err, // Bridge error forward enables
    output logic [NP-1:0]      pri_accept,  // Primary accept per port
    output logic [NP-1:0]      up_fwd,      // Upstream forward per port
    output logic [NP-1:0]      ur_cpl,      // UR completion per port
    output logic [NP-1:0]      err_report,  // Error report per port
    output logic [NP-1:0]      sig_serr,    // Signaled system error per port
    output logic [16*NP-1:0]   cmd_out      // Command words, for other logic
);
    localparam logic [11:0] OFFS [PCS_NPORTS] = '{PCS_OFF_P0, PCS_OFF_P1, PCS_OFF_P2,
        PCS_OFF_P8, PCS_OFF_P9, PCS_OFF_P10, PCS_OFF_P12, PCS_OFF_P13, PCS_OFF_P14};

    typedef struct packed {
        logic [NP-1:0][15:0] cmd;
        logic [15:0]         rdata;
        logic                hit;
    } pcs_bank_st_t;
    pcs_bank_st_t st_r, st_nxt;
    logic vis;
    logic [15:0] rsel;
    logic any;

    // Only the three visible ports see the bank
    assign vis = (cfg_port == PCS_VIS_A) || (cfg_port == PCS_VIS_B)
              || (cfg_port == PCS_VIS_C);

    // Register update: preload first, config write overrides same word
    always_comb begin
        st_nxt = st_r;
        rsel   = '0;
        any    = 1'b0;
        for (int i = 0; i < NP; i++) begin
            if (ld_en && ld_addr == OFFS[i])
                st_nxt.cmd[i] = ld_data & PCS_WMASK;
            if (vis && cfg_wr && cfg_addr == OFFS[i])
                st_nxt.cmd[i] = cfg_wdata & PCS_WMASK;
            if (cfg_addr == OFFS[i]) begin
                rsel = st_r.cmd[i] & PCS_WMASK;
                any  = 1'b1;
            end
        end
        st_nxt.hit   = vis && (cfg_rd || cfg_wr) && any;
        st_nxt.rdata = (vis && cfg_rd && any) ? rsel : 16'h0000;
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r.cmd   <= '0;
            st_r.rdata <= PCS_RESET_VAL;
            st_r.hit   <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cfg_rdata = st_r.rdata;
    assign cfg_hit   = st_r.hit;

    // One gate per port
    for (genvar g = 0; g < NP; g++) begin : g_port
        assign cmd_out[16*g +: 16] = st_r.cmd[g];
        pcs_port_gate u_gate (
            .clk         (clk),
            .rst_n       (rst_n),
            .cmd         (st_r.cmd[g]),
            .pri_req     (pri_req[g]),
            .pri_type    (pcs_tlp_t'(pri_type[2*g +: 2])),
            .sec_req     (sec_req[g]),
            .sec_type    (pcs_tlp_t'(sec_type[2*g +: 2])),
            .sec_np      (sec_np[g]),
            .err_det     (err_det[g]),
            .brg_fwd_err (brg_fwd_err[g]),
            .pri_accept  (pri_accept[g]),
            .up_fwd      (up_fwd[g]),
            .ur_cpl      (ur_cpl[g]),
            .err_report  (err_report[g]),
            .sig_serr    (sig_serr[g])
        );
    end

    // Assertions
    property p_io_gate;
        @(posedge clk) disable iff (!rst_n)
        (pri_req[0] && pri_type[1:0] == 2'b01 && !st_r.cmd[0][PCS_BIT_IO]) |=> !pri_accept[0];
    endproperty
    a_io_gate: assert property (p_io_gate) else $error("io accepted while disabled");
    property p_mem_gate;
        @(posedge clk) disable iff (!rst_n)
        (pri_req[0] && pri_type[1:0] == 2'b00 && st_r.cmd[0][PCS_BIT_MEM]) |=> pri_accept[0];
    endproperty
    a_mem_gate: assert property (p_mem_gate) else $error("mem refused while on");
    property p_ur;
        @(posedge clk) disable iff (!rst_n)
        (sec_req[0] && !sec_type[1] && sec_np[0] && !st_r.cmd[0][PCS_BIT_BM])
        |=> ur_cpl[0] && !up_fwd[0];
    endproperty
    a_ur: assert property (p_ur) else $error("missing UR completion");
    property p_fwd;
        @(posedge clk) disable iff (!rst_n)
        (sec_req[0] && !sec_type[1] && st_r.cmd[0][PCS_BIT_BM]) |=> up_fwd[0] && !ur_cpl[0];
    endproperty
    a_fwd: assert property (p_fwd) else $error("request not forwarded");
    property p_msg;
        @(posedge clk) disable iff (!rst_n)
        (sec_req[0] && sec_type[1]) |=> up_fwd[0] && !ur_cpl[0];
    endproperty
    a_msg: assert property (p_msg) else $error("message gated by bus master");
    property p_sse;
        @(posedge clk) disable iff (!rst_n)
        (!st_r.cmd[0][PCS_BIT_SERR] && !sig_serr[0]) |=> !sig_serr[0];
    endproperty
    a_sse: assert property (p_sse) else $error("system error set while disabled");
    property p_rep;
        @(posedge clk) disable iff (!rst_n)
        (err_det[0] && st_r.cmd[0][PCS_BIT_SERR]) |=> err_report[0] && sig_serr[0];
    endproperty
    a_rep: assert property (p_rep) else $error("error not reported");
    // Write then read back of port 9 through port 8; the read sees the written word
    sequence s_wr_p9;
        cfg_wr && cfg_port == PCS_VIS_B && cfg_addr == PCS_OFF_P9 && !ld_en;
    endsequence
    sequence s_rd_p9;
        cfg_rd && !cfg_wr && cfg_port == PCS_VIS_B && cfg_addr == PCS_OFF_P9 && !ld_en;
    endsequence
    property p_wr_rd;
        @(posedge clk) disable iff (!rst_n)
        s_wr_p9 ##1 s_rd_p9 |=> cfg_rdata == ($past(cfg_wdata, 2) & PCS_WMASK);
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("readback mismatch");
    property p_invis;
        @(posedge clk) disable iff (!rst_n)
        (!vis) |=> !cfg_hit && cfg_rdata == 16'h0000;
    endproperty
    a_invis: assert property (p_invis) else $error("bank seen from hidden port");

    // A refused write must leave every word as it was
    property p_hid_wr;
        @(posedge clk) disable iff (!rst_n)
        (!vis && cfg_wr && !ld_en) |=> $stable(cmd_out);
    endproperty
    a_hid_wr: assert property (p_hid_wr) else $error("hidden port wrote the bank");
    // The last word of the map must still decode
    property p_hit_p14;
        @(posedge clk) disable iff (!rst_n)
        (vis && cfg_rd && cfg_addr == PCS_OFF_P14) |=> cfg_hit;
    endproperty
    a_hit_p14: assert property (p_hit_p14) else $error("visible read of port 14 missed");
    // Preload lands unless a config write to the same word wins
    property p_ld_p0;
        @(posedge clk) disable iff (!rst_n)
        (ld_en && ld_addr == PCS_OFF_P0 && !(cfg_wr && cfg_addr == PCS_OFF_P0))
        |=> cmd_out[15:0] == ($past(ld_data) & PCS_WMASK);
    endproperty
    a_ld_p0: assert property (p_ld_p0) else $error("preload did not land");
    // Reserved bits never show on the read path
    property p_rsvd;
        @(posedge clk) disable iff (!rst_n)
        (cfg_rdata & ~PCS_WMASK) == 16'h0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
    // Reset clears words, status and read path; no disable here on purpose
    property p_rst_state;
        @(posedge clk)
        !rst_n |=> cmd_out == '0 && sig_serr == '0 && !cfg_hit && cfg_rdata == 16'h0000;
    endproperty
    a_rst_state: assert property (p_rst_state) else $error("state not cleared by reset");

    // Every port's gate, so a slip between port index and gate instance shows up
    for (genvar gp = 0; gp < NP; gp++) begin : g_chk
        property p_bm_off;
            @(posedge clk) disable iff (!rst_n)
            (sec_req[gp] && !sec_type[2*gp+1] && !st_r.cmd[gp][PCS_BIT_BM])
            |=> !up_fwd[gp] && ur_cpl[gp] == $past(sec_np[gp]);
        endproperty
        a_bm_off: assert property (p_bm_off) else $error("bus master clear not refusing");
        property p_cpl_pass;
            @(posedge clk) disable iff (!rst_n)
            (sec_req[gp] && sec_type[2*gp+1]) |=> up_fwd[gp] && !ur_cpl[gp];
        endproperty
        a_cpl_pass: assert property (p_cpl_pass) else $error("completion gated");
        property p_io_on;
            @(posedge clk) disable iff (!rst_n)
            (pri_req[gp] && pri_type[2*gp +: 2] == PCS_TLP_IO
                && st_r.cmd[gp][PCS_BIT_IO]) |=> pri_accept[gp];
        endproperty
        a_io_on: assert property (p_io_on) else $error("io refused while enabled");
        property p_mem_off;
            @(posedge clk) disable iff (!rst_n)
            (pri_req[gp] && pri_type[2*gp +: 2] == PCS_TLP_MEM
                && !st_r.cmd[gp][PCS_BIT_MEM]) |=> !pri_accept[gp];
        endproperty
        a_mem_off: assert property (p_mem_off) else $error("memory accepted while off");
        property p_rep_off;
            @(posedge clk) disable iff (!rst_n)
            (!st_r.cmd[gp][PCS_BIT_SERR]) |=> !err_report[gp];
        endproperty
        a_rep_off: assert property (p_rep_off) else $error("error reported while disabled");
        property p_brg_set;
            @(posedge clk) disable iff (!rst_n)
            (brg_fwd_err[gp] && st_r.cmd[gp][PCS_BIT_SERR]) |=> sig_serr[gp];
        endproperty
        a_brg_set: assert property (p_brg_set) else $error("bridge error lost");
    end
endmodule // pcs_cmd_bank
`default_nettype wire

// ===== pcs_pkg.sv
// Package for the per-port command shadow register bank.
// Assumes a 16-bit config-space access port and an EEPROM/I2C preload port.
package pcs_pkg;
    localparam int          PCS_NPORTS    = 9;
    localparam logic [11:0] PCS_OFF_P0    = 12'hE00;
    localparam logic [11:0] PCS_OFF_P1    = 12'hE02;
    localparam logic [11:0] PCS_OFF_P2    = 12'hE04;
    localparam logic [11:0] PCS_OFF_P8    = 12'hE10;
    localparam logic [11:0] PCS_OFF_P9    = 12'hE12;
    localparam logic [11:0] PCS_OFF_P10   = 12'hE14;
    localparam logic [11:0] PCS_OFF_P12   = 12'hE18;
    localparam logic [11:0] PCS_OFF_P13   = 12'hE1A;
    localparam logic [11:0] PCS_OFF_P14   = 12'hE1C;
    localparam int          PCS_BIT_IO    = 0;
    localparam int          PCS_BIT_MEM   = 1;
    localparam int          PCS_BIT_BM    = 2;
    localparam int          PCS_BIT_SERR  = 8;
    localparam logic [15:0] PCS_WMASK     = 16'h0107;
    localparam logic [15:0] PCS_RESET_VAL = 16'h0000;
    // Visible port numbers of the access ports
    localparam logic [3:0]  PCS_VIS_A     = 4'h0;
    localparam logic [3:0]  PCS_VIS_B     = 4'h8;
    localparam logic [3:0]  PCS_VIS_C     = 4'hC;
    typedef enum logic [1:0] {
        PCS_TLP_MEM = 2'b00,
        PCS_TLP_IO  = 2'b01,
        PCS_TLP_MSG = 2'b10,
        PCS_TLP_CPL = 2'b11
    } pcs_tlp_t;
endpackage

// ===== pcs_port_gate.sv
// One port's gating of traffic and error reporting by its command word.
// Assumes request strobes are single-cycle and synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pcs_port_gate
    import pcs_pkg::*;
(
    input  wire logic        clk,          // Core clock
    input  wire logic        rst_n,        // Sync reset, active low
    input  wire logic [15:0] cmd,          // Command word of this port
    input  wire logic        pri_req,      // Primary-side request strobe
    input  wire pcs_tlp_t    pri_type,     // Its type
    input  wire logic        sec_req,      // Secondary-side request strobe
    input  wire pcs_tlp_t    sec_type,     // Its type
    input  wire logic        sec_np,       // Secondary request is non-posted
    input  wire logic        err_det,      // Fatal/non-fatal error detected
    input  wire logic        brg_fwd_err,  // Bridge-control error forward enable
    output logic             pri_accept,   // Port responds on primary
    output logic             up_fwd,       // Forward upstream
    output logic             ur_cpl,       // Return UR completion
    output logic             err_report,   // Report error to root complex
    output logic             sig_serr      // Signaled system error status
);
    typedef struct packed {
        logic acc;
        logic fwd;
        logic ur;
        logic rep;
        logic sse;
    } pcs_gate_st_t;
    pcs_gate_st_t st_r, st_nxt;
    logic is_req_s;

    // Decode and forward decisions, registered one cycle after the strobe
    always_comb begin
        is_req_s   = (sec_type == PCS_TLP_MEM) || (sec_type == PCS_TLP_IO);
        st_nxt     = '0;
        st_nxt.sse = st_r.sse;
        st_nxt.acc = pri_req && ((pri_type == PCS_TLP_IO && cmd[PCS_BIT_IO])
                   || (pri_type == PCS_TLP_MEM && cmd[PCS_BIT_MEM])
                   || pri_type == PCS_TLP_MSG || pri_type == PCS_TLP_CPL);
        if (sec_req) begin
            // Messages and completions pass regardless of bus mastering
            st_nxt.fwd = !is_req_s || cmd[PCS_BIT_BM];
            st_nxt.ur  = is_req_s && !cmd[PCS_BIT_BM] && sec_np;
        end
        st_nxt.rep = err_det && cmd[PCS_BIT_SERR];
        // Status is sticky until reset; software clear lives outside this bank
        if ((err_det || brg_fwd_err) && cmd[PCS_BIT_SERR]) begin
            st_nxt.sse = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) st_r <= '0;
        else        st_r <= st_nxt;
    end

    assign pri_accept = st_r.acc;
    assign up_fwd     = st_r.fwd;
    assign ur_cpl     = st_r.ur;
    assign err_report = st_r.rep;
    assign sig_serr   = st_r.sse;
endmodule // pcs_port_gate
`default_nettype wire

// ===== pcs_far_model.sv
// Far-side model: root complex and downstream devices issuing requests.
// Assumes the bench changes its commands by non-blocking assignment at clk rise.
`timescale 1ns/1ps
`default_nettype none
module pcs_far_model
    import pcs_pkg::*;
(
    input  wire logic        clk,      // Core clock
    input  wire logic [8:0]  p_go,     // Primary requests to launch
    input  wire logic [8:0]  s_go,     // Secondary requests to launch
    input  wire logic [17:0] typ,      // Request types, two bits a port
    input  wire logic [8:0]  np,       // Non-posted flags
    output logic      [8:0]  pri_req,  // Primary request pulses
    output logic      [17:0] pri_type, // Primary types
    output logic      [8:0]  sec_req,  // Secondary request pulses
    output logic      [17:0] sec_type, // Secondary types
    output logic      [8:0]  sec_np    // Secondary non-posted flags
);
    // Idle pattern changes every cycle, so a stale type never looks valid
    logic [17:0] junk_r = 18'h2A5C3;
    always @(posedge clk) begin
        junk_r <= ~junk_r ^ {junk_r[16:0], junk_r[17]};
    end

    // Qualifiers carry real values only while their request is up
    always_comb begin
        pri_req = p_go;
        sec_req = s_go;
        for (int k = 0; k < 9; k++) begin
            pri_type[2*k+:2] = p_go[k] ? typ[2*k+:2] : junk_r[2*k+:2];
            sec_type[2*k+:2] = s_go[k] ? typ[2*k+:2] : ~junk_r[2*k+:2];
            sec_np[k]        = s_go[k] ? np[k] : junk_r[k];
        end
    end
endmodule // pcs_far_model
`default_nettype wire

// ===== pcs_cmd_bank_tb.sv
// Self-checking bench for the command register bank, with a queue scoreboard.
// Assumes pcs_pkg, pcs_cmd_bank and pcs_far_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pcs_cmd_bank_tb
    import pcs_pkg::*;
;
    localparam logic [11:0] OFFS [9] = '{PCS_OFF_P0, PCS_OFF_P1, PCS_OFF_P2, PCS_OFF_P8,
        PCS_OFF_P9, PCS_OFF_P10, PCS_OFF_P12, PCS_OFF_P13, PCS_OFF_P14};
    localparam logic [3:0]  PTS [5] = '{PCS_VIS_A, 4'h1, PCS_VIS_B, 4'h9, PCS_VIS_C};
    logic clk = 0, rst_n = 0, cfg_wr = 0, cfg_rd = 0, ld_en = 0, act = 0, act_q = 0, cfg_hit;
    logic [3:0]   cfg_port = 0;
    logic [11:0]  cfg_addr = 0, ld_addr = 0;
    logic [15:0]  cfg_wdata = 0, ld_data = 0, cfg_rdata;
    logic [8:0]   p_go = 0, s_go = 0, np = 0, err_det = 0, brg_fwd_err = 0, pri_req, sec_req;
    logic [8:0]   sec_np, pri_accept, up_fwd, ur_cpl, err_report, sig_serr, ss_m = 0;
    logic [17:0]  typ = 0, pri_type, sec_type;
    logic [143:0] cmd_out;
    logic [15:0]  cmd_m [9] = '{default: 16'h0000};
    logic [205:0] q [$];
    logic [205:0] got, exp_v;
    int errors = 0, total_checks = 0, cyc = 0;

    always #50 clk = ~clk;

    pcs_far_model far_u (.clk(clk), .p_go(p_go), .s_go(s_go), .typ(typ), .np(np),
        .pri_req(pri_req), .pri_type(pri_type), .sec_req(sec_req), .sec_type(sec_type),
        .sec_np(sec_np));
    pcs_cmd_bank #(.NP(9)) dut_u (.clk(clk), .rst_n(rst_n), .cfg_port(cfg_port),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit), .ld_en(ld_en), .ld_addr(ld_addr),
        .ld_data(ld_data), .pri_req(pri_req), .pri_type(pri_type), .sec_req(sec_req),
        .sec_type(sec_type), .sec_np(sec_np), .err_det(err_det), .brg_fwd_err(brg_fwd_err),
        .pri_accept(pri_accept), .up_fwd(up_fwd), .ur_cpl(ur_cpl), .err_report(err_report),
        .sig_serr(sig_serr), .cmd_out(cmd_out));

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // One cycle of config access, preload and random traffic; the expectation is queued
    task automatic op(input logic wr, rd, input logic [3:0] pt, input logic [11:0] a,
                      input logic [15:0] d, input logic le);
        logic [8:0] acc, fw, ur, er, ed, bf, nn, pg, sg;
        logic [17:0] ty;
        logic [15:0] c, r;
        logic [143:0] cv;
        logic h;
        ed = 9'($urandom); bf = 9'($urandom); nn = 9'($urandom);
        pg = 9'($urandom); sg = 9'($urandom); ty = 18'($urandom);
        h = (wr | rd) && (pt == PCS_VIS_A || pt == PCS_VIS_B || pt == PCS_VIS_C) && (a inside {OFFS});
        r = 16'h0000;
        // Gates use the word held before this cycle's writes land
        for (int k = 0; k < 9; k++) begin
            c = cmd_m[k];
            if (rd && h && a == OFFS[k]) r = c;
            acc[k] = pg[k] & (ty[2*k+1] | (ty[2*k+:2] == PCS_TLP_MEM ? c[1] : c[0]));
            fw[k]  = sg[k] & (ty[2*k+1] | c[2]);
            ur[k]  = sg[k] & ~ty[2*k+1] & ~c[2] & nn[k];
            er[k]  = ed[k] & c[8];
            ss_m[k] = ss_m[k] | (c[8] & (ed[k] | bf[k]));
            if (le && a == OFFS[k]) cmd_m[k] = ~d & PCS_WMASK;
            if (wr && h && a == OFFS[k]) cmd_m[k] = d & PCS_WMASK;
            cv[16*k+:16] = cmd_m[k];
        end
        @(posedge clk);
        cfg_wr <= wr; cfg_rd <= rd; cfg_port <= pt; cfg_addr <= a; cfg_wdata <= d;
        ld_en <= le; ld_addr <= a; ld_data <= ~d; p_go <= pg; s_go <= sg; typ <= ty;
        np <= nn; err_det <= ed; brg_fwd_err <= bf; act <= 1'b1;
        q.push_back({h, r, acc, fw, ur, er, ss_m, cv});
    endtask

    // Monitor: compares once the answer to a launched cycle has settled
    always @(posedge clk) act_q <= act;
    always @(negedge clk) begin
        if (act_q && q.size() > 0) begin
            got = {cfg_hit, cfg_rdata, pri_accept, up_fwd, ur_cpl, err_report, sig_serr, cmd_out};
            exp_v = q.pop_front();
            total_checks++;
            if (got !== exp_v) begin
                errors++;
                $display("ERROR outputs exp %h got %h", exp_v, got);
            end
        end
    end

    // Bounded run: a hang ends as a mismatch
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        void'($urandom(32'hF69194E3));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, then all-ones writes through each visible port in turn
        for (int k = 0; k < 9; k++) op(1'b0, 1'b1, PCS_VIS_A, OFFS[k], 16'h0000, 1'b0);
        for (int k = 0; k < 9; k++) op(1'b1, 1'b0, PTS[2*(k%3)], OFFS[k], 16'hFFFF, 1'b0);
        for (int k = 0; k < 9; k++) op(1'b0, 1'b1, PTS[k%5], OFFS[k], 16'h0000, 1'b0);
        op(1'b1, 1'b0, PCS_VIS_B, 12'hE06, 16'hFFFF, 1'b0);
        // Write then read back through port 8, as software would
        op(1'b1, 1'b0, PCS_VIS_B, PCS_OFF_P9, 16'hA5F2, 1'b0);
        op(1'b0, 1'b1, PCS_VIS_B, PCS_OFF_P9, 16'h0000, 1'b0);
        // Mixed writes, reads, preloads and refused ports with random traffic
        for (int i = 0; i < 400; i++) begin
            logic wr;
            int ai;
            wr = 1'($urandom);
            ai = $urandom % 10;
            op(wr, ~wr & 1'($urandom), PTS[$urandom % 5], ai == 9 ? 12'hE06 : OFFS[ai],
               16'($urandom), ($urandom % 4) == 0);
        end
        @(posedge clk);
        cfg_wr <= 1'b0; cfg_rd <= 1'b0; ld_en <= 1'b0; p_go <= '0; s_go <= '0; act <= 1'b0;
        repeat (3) @(posedge clk);
        summarize();
    end
endmodule // pcs_cmd_bank_tb
`default_nettype wire
